// ==== shared/bllf_pkg.sv ====
package bllf_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int CNT_W  = 10;   // Switching period counter width
   localparam int DT_W   = 4;    // Dead-time setting width
   localparam int V_W    = 12;   // Voltage code width, 10 mV per lsb
   localparam int RTY_W  = 3;    // Retry counter width

   // ----------------------------------------------------------------
   // Lockout thresholds in 10 mV codes
   // ----------------------------------------------------------------
   localparam logic [11:0] INPUT_LOW_VOLTAGE_LOCKOUT_LOW_CODE  = 12'h12c;  // 3 V
   localparam logic [11:0] INPUT_LOW_VOLTAGE_LOCKOUT_OPEN_CODE = 12'h1c2;  // 4.5 V
   localparam logic [11:0] INPUT_LOW_VOLTAGE_LOCKOUT_HIGH_CODE = 12'h438;  // 10.8 V
   localparam logic [11:0] INPUT_LOW_VOLTAGE_LOCKOUT_MIN_CODE  = 12'h11d;  // 2.85 V
   localparam logic [11:0] INPUT_LOW_VOLTAGE_LOCKOUT_MAX_CODE  = 12'h640;  // 16 V

   // ----------------------------------------------------------------
   // Fields, resets, timing
   // ----------------------------------------------------------------
   localparam int          AFC_EN_BIT   = 0;       // Auxiliary settings bit
   localparam logic [3:0]  DT_RESET     = 4'h8;
   localparam logic [3:0]  DT_MIN       = 4'h1;
   localparam int          OV_PCT       = 15;
   localparam int          OV_PCT_DEN   = 100;
   localparam int          CLK_HZ       = 25000000;
   localparam int          FLT_DELAY_US = 100;
   localparam int          FLT_DELAY_CYC = FLT_DELAY_US * (CLK_HZ / 1000000);
   localparam int          RETRY_US     = 10;
   localparam int          RETRY_CYC    = RETRY_US * (CLK_HZ / 1000000);

   // ----------------------------------------------------------------
   // Enumerations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {STRAP_LOW, STRAP_OPEN, STRAP_HIGH} bllf_strap_type;
   typedef enum logic [1:0] {UV_IGNORE, UV_DELAYED, UV_RETRY} bllf_uv_resp_type;
   typedef enum logic       {OV_SHUTDOWN, OV_CROWBAR} bllf_ov_resp_type;

endpackage : bllf_pkg

// ==== shared/bllf_gate_if.sv ====
`timescale 1ns/10ps
interface bllf_gate_if;
   logic                      run;       // Power stage allowed to switch
   logic                      crowbar;   // Hold low side on, high side off
   logic [bllf_pkg::CNT_W-1:0] period;   // Cycles per switching period
   logic [bllf_pkg::CNT_W-1:0] hs_on;    // High-side stop count; high side is on for hs_on minus dead cycles
   logic [bllf_pkg::CNT_W-1:0] ls_on;    // Low-side on cycles
   logic [bllf_pkg::DT_W-1:0]  dead;     // Non-overlap cycles
   logic                      hs;
   logic                      ls;
   logic                      cyc_end;

   modport ctrl (output run, crowbar, period, hs_on, ls_on, dead,
                 input hs, ls, cyc_end);
   modport drv  (input run, crowbar, period, hs_on, ls_on, dead,
                 output hs, ls, cyc_end);
endinterface : bllf_gate_if

// ==== src/bllf_gate_drive.sv ====
`timescale 1ns/10ps
// Period counter producing the two non-overlapping gate drives
module bllf_gate_drive
(
   // Clock and reset
   input  wire logic  mclk,
   input  wire logic  resetn,
   // Control side
   bllf_gate_if.drv   gif
);

   logic [bllf_pkg::CNT_W-1:0] cnt_reg;
   logic                       hs_reg;
   logic                       ls_reg;
   logic                       hs_next;
   logic                       ls_next;
   logic                       wrap;
   logic [bllf_pkg::CNT_W-1:0] ls_start;
   logic [bllf_pkg::CNT_W-1:0] ls_stop;

   assign wrap     = (cnt_reg >= gif.period - 1'b1);
   assign ls_start = gif.hs_on + bllf_pkg::CNT_W'(gif.dead);
   assign ls_stop  = ls_start + gif.ls_on;

   // High side only after dead band, never with the low side
   assign hs_next = gif.run && !gif.crowbar && !ls_reg &&
                    (cnt_reg >= bllf_pkg::CNT_W'(gif.dead)) &&
                    (cnt_reg < gif.hs_on);
   // Low side cut at ls_stop stops negative inductor current
   assign ls_next = !hs_reg && (gif.crowbar ||
                    (gif.run && (cnt_reg >= ls_start) &&
                     (cnt_reg < ls_stop) && !hs_next));

   assign gif.hs      = hs_reg;
   assign gif.ls      = ls_reg;
   assign gif.cyc_end = wrap;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_reg <= '0;
         hs_reg  <= 1'b0;
         ls_reg  <= 1'b0;
      end
      else
      begin
         cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
         hs_reg  <= hs_next;
         ls_reg  <= ls_next;
      end
   end

endmodule : bllf_gate_drive

// ==== src/bllf_ctrl.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Never drive both gates at once
// - Closed-loop dead-time trims toward minimum duty
// - Diode emulation cuts low side at light load
// - Diode emulation only when single phase
// - Adaptive frequency needs settings bit0 and emulation
// - Shorten low side, then high side, same rate
// - Below half nominal duty, rate scales with duty
// - Rate reduced in quantised steps only
// - Adaptive frequency blocked: sharing, sync in/out
// - Strap low/open/high gives 3/4.5/10.8 V
// - Bus threshold 2.85 to 16 V overrides strap
// - Lockout response ignore, delayed or retry shutdown
// - Delayed lockout shutdown latches until restart
// - Default lockout response shuts down, auto recovers
// - Output 15 percent high drops power good
// - Crowbar response: high off, low held on
// - Default overvoltage shuts down, auto recovers
// - External clock forces immediate overvoltage shutdown
module bllf_ctrl
#(
   parameter int FLT_DELAY = bllf_pkg::FLT_DELAY_CYC,
   parameter int RETRY_GAP = bllf_pkg::RETRY_CYC,
   parameter int STEP_SH   = 2
)
(
   // Clock and reset
   input  wire logic                          mclk,
   input  wire logic                          resetn,
   // Converter configuration
   input  wire logic                          enable,
   input  wire logic [bllf_pkg::CNT_W-1:0]    programmed_switching_rate_command,
   input  wire logic [bllf_pkg::CNT_W-1:0]    min_rate_period,
   input  wire logic [bllf_pkg::CNT_W-1:0]    nominal_duty,
   input  wire logic [bllf_pkg::CNT_W-1:0]    duty_demand,
   input  wire logic [bllf_pkg::CNT_W-1:0]    ls_demand,
   input  wire logic                          duty_sample,
   input  wire logic                          diode_emulation_req,
   input  wire logic [7:0]                    aux_settings,
   input  wire logic                          multi_phase,
   input  wire logic                          current_share,
   input  wire logic                          sync_autodetect,
   input  wire logic                          sync_clock_present,
   input  wire logic                          sync_clock_out,
   input  wire logic                          ext_clock,
   // Lockout
   input  wire logic [1:0]                    lockout_strap,
   input  wire logic                          lockout_override,
   input  wire logic [bllf_pkg::V_W-1:0]      lockout_bus_code,
   input  wire logic [bllf_pkg::V_W-1:0]      input_voltage_code,
   input  wire logic [1:0]                    lockout_response,
   input  wire logic [bllf_pkg::RTY_W-1:0]    retry_limit,
   input  wire logic                          restart_cmd,
   // Overvoltage
   input  wire logic [bllf_pkg::V_W-1:0]      output_sense_input,
   input  wire logic [bllf_pkg::V_W-1:0]      target_code,
   input  wire logic                          ov_response,
   // Outputs
   output logic                               high_side_gate_drive,
   output logic                               low_side_gate_drive,
   output logic                               power_good_output,
   output logic                               input_low_voltage_lockout,
   output logic                               ov_fault,
   output logic                               latched_off,
   output logic [bllf_pkg::CNT_W-1:0]         active_period,
   output logic [bllf_pkg::DT_W-1:0]          dead_setting
);

   if (FLT_DELAY < 1 || RETRY_GAP < 1 || FLT_DELAY > 65535 || RETRY_GAP > 65535 ||
       STEP_SH < 0 || STEP_SH > 6)
   begin : g_bad_param
      $error("bllf_ctrl: bad parameter");
   end

   // ----------------------------------------------------------------
   // Mode qualification
   // ----------------------------------------------------------------
   logic de_on;
   logic afc_on;
   assign de_on  = diode_emulation_req && !multi_phase;
   assign afc_on = aux_settings[bllf_pkg::AFC_EN_BIT] && de_on && !current_share &&
                   !(sync_autodetect && sync_clock_present) &&
                   !sync_clock_out;

   // ----------------------------------------------------------------
   // Lockout threshold and detection
   // ----------------------------------------------------------------
   logic [bllf_pkg::V_W-1:0] strap_code;
   logic [bllf_pkg::V_W-1:0] bus_clip;
   logic [bllf_pkg::V_W-1:0] uv_thresh;
   logic                     uv_now;
   assign strap_code = (lockout_strap == bllf_pkg::STRAP_LOW)  ? bllf_pkg::INPUT_LOW_VOLTAGE_LOCKOUT_LOW_CODE :
                       (lockout_strap == bllf_pkg::STRAP_HIGH) ? bllf_pkg::INPUT_LOW_VOLTAGE_LOCKOUT_HIGH_CODE :
                       bllf_pkg::INPUT_LOW_VOLTAGE_LOCKOUT_OPEN_CODE;
   assign bus_clip   = (lockout_bus_code < bllf_pkg::INPUT_LOW_VOLTAGE_LOCKOUT_MIN_CODE) ? bllf_pkg::INPUT_LOW_VOLTAGE_LOCKOUT_MIN_CODE :
                       (lockout_bus_code > bllf_pkg::INPUT_LOW_VOLTAGE_LOCKOUT_MAX_CODE) ? bllf_pkg::INPUT_LOW_VOLTAGE_LOCKOUT_MAX_CODE :
                       lockout_bus_code;
   assign uv_thresh  = lockout_override ? bus_clip : strap_code;
   assign uv_now     = input_voltage_code < uv_thresh;

   // ----------------------------------------------------------------
   // Overvoltage compare
   // ----------------------------------------------------------------
   logic [bllf_pkg::V_W+7:0] ov_lhs;
   logic [bllf_pkg::V_W+7:0] ov_rhs;
   logic                     ov_now;
   assign ov_lhs = 20'(output_sense_input) * 20'(bllf_pkg::OV_PCT_DEN);
   assign ov_rhs = 20'(target_code) * 20'(bllf_pkg::OV_PCT_DEN + bllf_pkg::OV_PCT);
   assign ov_now = ov_lhs > ov_rhs;
   // External clock allows only the shutdown response
   logic ov_crowbar_sel;
   assign ov_crowbar_sel = (ov_response == bllf_pkg::OV_CROWBAR) && !ext_clock;

   // ----------------------------------------------------------------
   // Fault supervisor
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {S_OFF, S_RUN, S_UV_WAIT, S_SHUT, S_GAP, S_LATCH} bllf_state_type;
   bllf_state_type           state_reg;
   bllf_state_type           state_next;
   logic [15:0]              tmr_reg;
   logic [15:0]              tmr_next;
   logic [bllf_pkg::RTY_W-1:0] rty_reg;
   logic [bllf_pkg::RTY_W-1:0] rty_next;
   logic                     crow_reg;
   logic                     crow_next;
   logic                     uv_resp_ret;
   logic                     flt_now;
   assign uv_resp_ret = (lockout_response == bllf_pkg::UV_RETRY) ||
                        (lockout_response == 2'h3);
   assign flt_now     = ov_now || (uv_now && lockout_response != bllf_pkg::UV_IGNORE);

   always_comb
   begin
      state_next = state_reg;
      tmr_next   = (tmr_reg != 16'h0000) ? tmr_reg - 16'h0001 : tmr_reg;
      rty_next   = rty_reg;
      crow_next  = crow_reg;
      case (state_reg)
         S_OFF:
            if (enable && !uv_now && !ov_now)
               state_next = S_RUN;
         S_RUN:
            if (!enable)
               state_next = S_OFF;
            else if (ov_now)
            begin
               state_next = S_SHUT;
               crow_next  = ov_crowbar_sel;
            end
            else if (uv_now && lockout_response == bllf_pkg::UV_DELAYED)
            begin
               state_next = S_UV_WAIT;
               tmr_next   = 16'(FLT_DELAY);
            end
            else if (uv_now && uv_resp_ret)
               state_next = S_SHUT;
            else if (rty_reg != '0 && tmr_reg == 16'h0000)
               rty_next = '0;
         S_UV_WAIT:
            if (ov_now)
            begin
               state_next = S_SHUT;
               crow_next  = ov_crowbar_sel;
            end
            else if (!uv_now)
               state_next = S_RUN;
            else if (tmr_reg == 16'h0000)
               state_next = S_LATCH;
         S_SHUT:
         begin
            state_next = S_GAP;
            tmr_next   = 16'(RETRY_GAP);
         end
         S_GAP:
            if (tmr_reg == 16'h0000 && !flt_now)
            begin
               state_next = S_RUN;
               crow_next  = 1'b0;
               rty_next   = rty_reg + 1'b1;
               tmr_next   = 16'(FLT_DELAY);
            end
            else if (tmr_reg == 16'h0000)
            begin
               // Attempt met the fault again: count it, give up at the limit
               rty_next   = rty_reg + 1'b1;
               state_next = (retry_limit != '0 && rty_reg >= retry_limit) ?
                            S_LATCH : S_SHUT;
            end
         S_LATCH:
            if (restart_cmd)
            begin
               state_next = S_OFF;
               rty_next   = '0;
               crow_next  = 1'b0;
            end
         default:
            state_next = S_OFF;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= S_OFF;
         tmr_reg   <= 16'h0000;
         rty_reg   <= '0;
         crow_reg  <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         tmr_reg   <= tmr_next;
         rty_reg   <= rty_next;
         crow_reg  <= crow_next;
      end
   end

   // ----------------------------------------------------------------
   // Dead-time trim and adaptive rate
   // ----------------------------------------------------------------
   logic [bllf_pkg::DT_W-1:0]  dt_reg;
   logic [bllf_pkg::DT_W-1:0]  dt_next;
   logic                       dir_reg;
   logic [bllf_pkg::CNT_W-1:0] prev_duty_reg;
   logic                       worse;
   // Hill climb: keep stepping while duty falls, reverse when it grows
   assign worse   = duty_demand > prev_duty_reg;
   assign dt_next = ((dir_reg ^ worse) && dt_reg > bllf_pkg::DT_MIN) ? dt_reg - 1'b1 :
                    (!(dir_reg ^ worse) && dt_reg != '1) ? dt_reg + 1'b1 : dt_reg;

   logic [bllf_pkg::CNT_W-1:0] half_nom;
   logic [bllf_pkg::CNT_W-1:0] hs_cmd;
   logic [bllf_pkg::CNT_W-1:0] span;
   logic [3*bllf_pkg::CNT_W-1:0] frac;
   logic [3*bllf_pkg::CNT_W-1:0] den;
   logic [bllf_pkg::CNT_W-1:0] per_raw;
   logic [bllf_pkg::CNT_W-1:0] per_q;
   logic [bllf_pkg::CNT_W-1:0] ls_cmd;
   assign half_nom = nominal_duty >> 1;
   // Low side shrinks first; high side then shrinks at fixed rate
   assign ls_cmd   = de_on ? ls_demand : programmed_switching_rate_command;
   assign hs_cmd   = duty_demand;
   assign span     = min_rate_period - programmed_switching_rate_command;
   // Rate, not period, is linear in duty, so the period needs a divide
   assign den      = 30'(programmed_switching_rate_command) * 30'(nominal_duty) +
                     30'(span) * 30'(hs_cmd) * 30'd2;
   assign frac     = (den == '0) ? '0 :
                     30'(programmed_switching_rate_command) * 30'(min_rate_period) *
                     30'(nominal_duty) / den;
   assign per_raw  = (afc_on && hs_cmd < half_nom) ? frac[bllf_pkg::CNT_W-1:0] :
                     programmed_switching_rate_command;
   assign per_q    = (per_raw >> STEP_SH) << STEP_SH;

   logic run_w;
   bllf_gate_if gif ();
   assign run_w       = (state_reg == S_RUN) || (state_reg == S_UV_WAIT);
   assign gif.run     = run_w;
   assign gif.crowbar = crow_reg && (state_reg == S_SHUT || state_reg == S_GAP);
   assign gif.period  = (per_q < programmed_switching_rate_command) ?
                        programmed_switching_rate_command : per_q;
   assign gif.hs_on   = hs_cmd;
   assign gif.ls_on   = ls_cmd;
   assign gif.dead    = dt_reg;

   bllf_gate_drive u_drive
   (
      .mclk   (mclk),
      .resetn (resetn),
      .gif    (gif)
   );

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         dt_reg        <= bllf_pkg::DT_RESET;
         dir_reg       <= 1'b0;
         prev_duty_reg <= '0;
      end
      else if (duty_sample && run_w)
      begin
         dt_reg        <= dt_next;
         dir_reg       <= dir_reg ^ worse;
         prev_duty_reg <= duty_demand;
      end
   end

   // ----------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         high_side_gate_drive      <= 1'b0;
         low_side_gate_drive       <= 1'b0;
         power_good_output         <= 1'b0;
         input_low_voltage_lockout <= 1'b0;
         ov_fault                  <= 1'b0;
         latched_off               <= 1'b0;
         active_period             <= '0;
         dead_setting              <= bllf_pkg::DT_RESET;
      end
      else
      begin
         high_side_gate_drive      <= gif.hs && !gif.ls;
         low_side_gate_drive       <= gif.ls && !gif.hs;
         power_good_output         <= run_w && !ov_now;
         input_low_voltage_lockout <= uv_now;
         ov_fault                  <= ov_now;
         latched_off               <= state_next == S_LATCH;
         active_period             <= gif.period;
         dead_setting              <= dt_reg;
      end
   end

endmodule : bllf_ctrl

// ==== sim/bllf_ctrl_props.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port-level checks for the light-load and fault controller
// ----------------------------------------------------------------
module bllf_ctrl_props
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        resetn,
   // Configuration
   input wire logic        enable,
   input wire logic        ext_clock,
   input wire logic [1:0]  lockout_response,
   input wire logic        restart_cmd,
   input wire logic        ov_response,
   // Sensing
   input wire logic [11:0] output_sense_input,
   input wire logic [11:0] target_code,
   // Outputs
   input wire logic        high_side_gate_drive,
   input wire logic        low_side_gate_drive,
   input wire logic        power_good_output,
   input wire logic        input_low_voltage_lockout,
   input wire logic        ov_fault,
   input wire logic        latched_off,
   input wire logic [3:0]  dead_setting
);
   // Widened so the 15 percent margin compares exactly in integers
   wire logic ov_now    = 24'(output_sense_input) * 24'd100 > 24'(target_code) * 24'd115;
   wire logic gates_off = !high_side_gate_drive && !low_side_gate_drive;
   wire logic crowbar   = !high_side_gate_drive && low_side_gate_drive;
   wire logic cb_req    = ov_fault && ov_response && !ext_clock;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);

   chk_no_overlap: assert property (!(high_side_gate_drive && low_side_gate_drive))
      else $error("both gate drives on");
   chk_dead_floor: assert property (dead_setting >= bllf_pkg::DT_MIN)
      else $error("dead time below floor");
   chk_ov_detect: assert property (ov_now |=> ov_fault && !power_good_output)
      else $error("overvoltage not flagged");
   chk_ov_shutoff: assert property ((ov_fault && !ov_response)[*4] |-> gates_off)
      else $error("gates on during overvoltage");
   chk_crowbar_hold: assert property (cb_req[*4] |-> crowbar)
      else $error("low side not held on");
   chk_ext_shutoff: assert property ((ov_fault && ext_clock)[*4] |-> gates_off)
      else $error("external clock fault not shut down");
   chk_uv_shutoff: assert property ((input_low_voltage_lockout && lockout_response[1])[*4]
      |-> !high_side_gate_drive)
      else $error("switching during lockout");
   chk_latch_hold: assert property (latched_off && enable && !restart_cmd |=> latched_off)
      else $error("latched shutdown released");
   chk_latch_quiet: assert property (latched_off[*4] |-> !high_side_gate_drive)
      else $error("switching while latched off");

   cov_crowbar: cover property (cb_req && low_side_gate_drive);
   cov_latched: cover property ($rose(latched_off));
   cov_uv_trip: cover property ($rose(input_low_voltage_lockout));
endmodule : bllf_ctrl_props

bind bllf_ctrl bllf_ctrl_props u_props (.*);

// ==== sim/bllf_stage_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Power stage stand-in: times switching cycles, flags shoot-through
// ----------------------------------------------------------------
module bllf_stage_model
(
   // Clock and reset
   input  wire logic mclk,
   input  wire logic resetn,
   // Gate drives
   input  wire logic hs,
   input  wire logic ls,
   // Observations
   output logic      shoot,
   output int        pulses,
   output int        period
);
   logic hs_q;
   int   cnt;

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         hs_q   <= 1'b0;
         cnt    <= 0;
         shoot  <= 1'b0;
         pulses <= 0;
         period <= 0;
      end
      else
      begin
         hs_q <= hs;
         cnt  <= cnt + 1;
         // Both switches on shorts the supply; kept sticky for the bench
         if (hs && ls)
            shoot <= 1'b1;
         if (hs && !hs_q)
         begin
            pulses <= pulses + 1;
            period <= cnt + 1;
            cnt    <= 0;
         end
      end
   end
endmodule : bllf_stage_model

// ==== sim/buck_light_load_and_fault_control_test.sv ====
`timescale 1ns/10ps
module buck_light_load_and_fault_control_test;
   // ----------------------------------------------------------------
   // Stimulus and observation
   // ----------------------------------------------------------------
   logic        mclk = 1'b0, resetn = 1'b0, enable = 1'b1;
   logic [9:0]  programmed_switching_rate_command = 10'h064, min_rate_period = 10'h190;
   logic [9:0]  nominal_duty = 10'h028, duty_demand = 10'h00a, ls_demand = 10'h01e;
   logic [7:0]  aux_settings = 8'h00;
   logic        duty_sample = 1'b0, diode_emulation_req = 1'b0, multi_phase = 1'b0;
   logic        current_share = 1'b0, sync_autodetect = 1'b0, sync_clock_present = 1'b0;
   logic        sync_clock_out = 1'b0, ext_clock = 1'b0, lockout_override = 1'b0;
   logic        restart_cmd = 1'b0, ov_response = 1'b0;
   logic [1:0]  lockout_strap = 2'h1, lockout_response = 2'h2;
   logic [2:0]  retry_limit = 3'h0;
   logic [11:0] lockout_bus_code = 12'h000, input_voltage_code = 12'h4b0;
   logic [11:0] output_sense_input = 12'h064, target_code = 12'h064;
   logic        high_side_gate_drive, low_side_gate_drive, power_good_output;
   logic        input_low_voltage_lockout, ov_fault, latched_off, shoot;
   logic [9:0]  active_period;
   logic [3:0]  dead_setting;
   int          pulses, period, n_mismatch = 0, checks = 0;
   // Config bits: emulation, adaptive enable, phase group, sharing, autodetect, sync in, out
   logic [6:0]  afc_cfg [8] = '{7'h60, 7'h70, 7'h68, 7'h66, 7'h61, 7'h20, 7'h40, 7'h64};
   logic        afc_slow [8] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   wire logic [5:0] flags = {high_side_gate_drive, low_side_gate_drive, power_good_output,
                             input_low_voltage_lockout, ov_fault, latched_off};

   always #20 mclk = ~mclk;

   bllf_ctrl #(.FLT_DELAY(4), .RETRY_GAP(3)) DUT (.*);
   bllf_stage_model U_STAGE (.mclk(mclk), .resetn(resetn), .hs(high_side_gate_drive),
                             .ls(low_side_gate_drive), .shoot(shoot), .pulses(pulses),
                             .period(period));

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc

   task automatic close_out;
      if (n_mismatch == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task automatic chk(input logic [11:0] got, input logic [11:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic hang;
      n_mismatch++;
      $display("unexpected at %0t: wait ran out", $time);
      close_out();
   endtask : hang

   task automatic pulses_wait(input int n);
      int k;
      k = pulses + n;
      checks++;
      for (int i = 0; pulses < k; i++)
      begin
         if (i == 3000)
            hang();
         cyc(1);
      end
   endtask : pulses_wait

   task automatic wait_latch(input logic v);
      checks++;
      for (int i = 0; latched_off !== v; i++)
      begin
         if (i == 2000)
            hang();
         cyc(1);
      end
   endtask : wait_latch

   task automatic quiet(input int n);
      int p;
      p = pulses;
      cyc(n);
      chk(12'(pulses - p), 12'h000);
   endtask : quiet

   task automatic restart;
      restart_cmd = 1'b1;
      cyc(1);
      restart_cmd = 1'b0;
      wait_latch(1'b0);
   endtask : restart

   task automatic uv_case(input logic [1:0] s, input logic o, input logic [11:0] b, v,
                          input logic e);
      lockout_strap = s;
      lockout_override = o;
      lockout_bus_code = b;
      input_voltage_code = v;
      cyc(2);
      chk(12'(input_low_voltage_lockout), 12'(e));
   endtask : uv_case

   // Target 2.00 V, sense 2.31 V is just past the 15 percent margin
   task automatic ov_case(input logic r, x, input logic [1:0] g);
      ov_response = r;
      ext_clock = x;
      target_code = 12'h0c8;
      output_sense_input = 12'h0e7;
      cyc(2);
      chk(12'({ov_fault, power_good_output}), 12'h002);
      cyc(8);
      chk(12'({high_side_gate_drive, low_side_gate_drive}), 12'(g));
      output_sense_input = 12'h0c8;
      pulses_wait(2);
      chk(12'(power_good_output), 12'h001);
      ov_response = 1'b0;
      ext_clock = 1'b0;
   endtask : ov_case

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial
   begin
      cyc(5);
      chk(12'(flags), 12'h000);
      chk(12'(dead_setting), 12'h008);
      cyc(1);
      resetn = 1'b1;
      pulses_wait(3);
      chk(12'(period), 12'h064);
      repeat (8)
      begin
         duty_sample = 1'b1;
         cyc(1);
         duty_sample = 1'b0;
         cyc(15);
      end
      lockout_response = 2'h0;
      uv_case(2'h0, 1'b0, 12'h000, 12'h12b, 1'b1);
      uv_case(2'h0, 1'b0, 12'h000, 12'h12d, 1'b0);
      uv_case(2'h1, 1'b0, 12'h000, 12'h1c1, 1'b1);
      uv_case(2'h1, 1'b0, 12'h000, 12'h1c3, 1'b0);
      uv_case(2'h2, 1'b0, 12'h000, 12'h437, 1'b1);
      uv_case(2'h2, 1'b0, 12'h000, 12'h439, 1'b0);
      uv_case(2'h3, 1'b0, 12'h000, 12'h1c1, 1'b1);
      uv_case(2'h1, 1'b1, 12'h3e8, 12'h3e9, 1'b0);
      uv_case(2'h1, 1'b1, 12'h3e8, 12'h3e7, 1'b1);
      uv_case(2'h1, 1'b1, 12'h064, 12'h11e, 1'b0);
      uv_case(2'h1, 1'b1, 12'h064, 12'h11c, 1'b1);
      uv_case(2'h1, 1'b1, 12'h7d0, 12'h63f, 1'b1);
      pulses_wait(3);
      lockout_override = 1'b0;
      lockout_response = 2'h2;
      input_voltage_code = 12'h190;
      cyc(10);
      quiet(500);
      input_voltage_code = 12'h4b0;
      pulses_wait(2);
      lockout_response = 2'h1;
      input_voltage_code = 12'h190;
      wait_latch(1'b1);
      input_voltage_code = 12'h4b0;
      quiet(500);
      restart();
      pulses_wait(2);
      lockout_response = 2'h3;
      retry_limit = 3'h2;
      input_voltage_code = 12'h190;
      wait_latch(1'b1);
      input_voltage_code = 12'h4b0;
      restart();
      retry_limit = 3'h0;
      output_sense_input = 12'h073;
      cyc(3);
      chk(12'(ov_fault), 12'h000);
      ov_case(1'b0, 1'b0, 2'b00);
      ov_case(1'b1, 1'b0, 2'b01);
      ov_case(1'b1, 1'b1, 2'b00);
      aux_settings[7:1] = 7'h55;
      for (int i = 0; i < 8; i++)
      begin
         {diode_emulation_req, aux_settings[0], multi_phase, current_share, sync_autodetect,
          sync_clock_present, sync_clock_out} = afc_cfg[i];
         cyc(2000);
         pulses_wait(2);
         chk(12'(period), afc_slow[i] ? 12'h0a0 : 12'h064);
      end
      diode_emulation_req = 1'b0;
      duty_demand = 10'h01e;
      cyc(20);
      diode_emulation_req = 1'b1;
      cyc(2000);
      pulses_wait(2);
      chk(12'(period), 12'h064);
      chk(12'(shoot), 12'h000);
      close_out();
   end
endmodule : buck_light_load_and_fault_control_test
